/* sslc_host.sv */
/*
 controller end: shifts a 32-bit word msb first, then strobes load low.
 assumes clk is the system clock; shift clock derived by a divider.
*/
`timescale 1ns/1ps
module sslc_host (
   input  wire logic        clk,
   input  wire logic        resetn,
   sslc_if.host             link,
   input  wire logic        start,
   input  wire logic [31:0] word,
   input  wire logic        clear,
   output logic             busy,
   output logic             chain_out
);
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_SHIFT = 2'b01,
      ST_LOAD  = 2'b11
   } sslc_hst_e;

   typedef struct packed {
      sslc_hst_e   state;
      logic [31:0] data;
      logic [5:0]  bitn;
      logic [3:0]  half;
      logic        sclk;
      logic        sdat;
      logic        load_n;
      logic        clr;
      logic        busy;
      logic        chain;
   } sslc_hst_s;

   sslc_hst_s st_r;
   sslc_hst_s st_nxt;

   ////////////////////////////////////////////////////////////////////////
   // sequencer
   always_comb begin
      st_nxt = st_r;
      st_nxt.clr = clear;
      st_nxt.chain = link.serial_out;
      unique case (st_r.state)
         ST_IDLE: begin
            st_nxt.load_n = 1'b1;
            if (start) begin
               st_nxt.state = ST_SHIFT;
               st_nxt.data  = word;
               st_nxt.sdat  = word[31]; // switch 31 first
               st_nxt.bitn  = '0;
               st_nxt.half  = '0;
               st_nxt.busy  = 1'b1;
            end
         end
         ST_SHIFT: begin
            // load stays high during shifting
            if (st_r.half == sslc_pkg::HALF_LAST) begin
               st_nxt.half = '0;
               st_nxt.sclk = !st_r.sclk;
               if (st_r.sclk) begin
                  // falling edge: present next bit
                  if (st_r.bitn == sslc_pkg::BIT_LAST) begin
                     st_nxt.state  = ST_LOAD; // full word first
                     st_nxt.load_n = 1'b0;
                  end else begin
                     st_nxt.bitn = st_r.bitn + 6'h01;
                     st_nxt.data = {st_r.data[30:0], 1'b0};
                     st_nxt.sdat = st_r.data[30];
                  end
               end
            end else begin
               st_nxt.half = st_r.half + 4'h1;
            end
         end
         ST_LOAD: begin
            // one cycle low strobe then back high
            st_nxt.load_n = 1'b1;
            st_nxt.state  = ST_IDLE;
            st_nxt.busy   = 1'b0;
         end
         default: st_nxt.state = ST_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_r <= '{state: ST_IDLE, load_n: 1'b1, default: '0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign link.shift_clk    = st_r.sclk;
   assign link.serial_in    = st_r.sdat;
   assign link.latch_load_n = st_r.load_n;
   assign link.latch_clear  = st_r.clr;
   assign busy              = st_r.busy;
   assign chain_out         = st_r.chain;
endmodule

/* sslc_pkg.sv */
/*
 serial switch latch control package: widths and timing counts shared
 by the device end and the controller end.
 assumes a single 25 MHz system clock on both ends.
*/
package sslc_pkg;
   localparam int unsigned NUM_SW      = 32;
   localparam int unsigned CLK_HZ      = 25000000;
   localparam int unsigned SCLK_MAX_HZ = 20000000;
   // half period of the shift clock in system cycles, rounded up
   localparam int unsigned HALF_CYC_RAW =
      (CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
   localparam int unsigned HALF_CYC    = (HALF_CYC_RAW < 1) ? 1 : HALF_CYC_RAW;
   localparam logic [31:0] SW_RESET    = 32'h0000_0000;
   localparam logic [5:0]  BIT_LAST    = 6'h1f;
   localparam logic [3:0]  HALF_LAST   = 4'(HALF_CYC - 1);
endpackage

/* sslc_if.sv */
/*
 serial control link between controller and switch device.
 assumes both ends clocked by the same system clock.
*/
`timescale 1ns/1ps
interface sslc_if;
   logic shift_clk;
   logic serial_in;
   logic serial_out;
   logic latch_load_n;
   logic latch_clear;

   modport device (
      input  shift_clk,
      input  serial_in,
      input  latch_load_n,
      input  latch_clear,
      output serial_out
   );
   modport host (
      output shift_clk,
      output serial_in,
      output latch_load_n,
      output latch_clear,
      input  serial_out
   );
endinterface

/* sslc_device.sv */
/*
 device end: 32-stage shift register, 32 switch latches and chain out.
 assumes link pins are synchronous to clk; edges are found by sampling.
*/
`timescale 1ns/1ps
module sslc_device (
   input  wire logic        clk,
   input  wire logic        resetn,
   sslc_if.device           link,
   output logic [31:0]      switch_on
);
   typedef struct packed {
      logic [31:0] shreg;
      logic [31:0] latch;
      logic        sclk_d;
      logic        sout;
      logic [31:0] sw;
   } sslc_dev_s;

   sslc_dev_s st_r;
   sslc_dev_s st_nxt;
   logic [31:0] shreg_new;

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      st_nxt = st_r;
      shreg_new = st_r.shreg;
      st_nxt.sclk_d = link.shift_clk;
      if (link.shift_clk && !st_r.sclk_d) begin
         // msb first: first bit walks up to stage 31
         shreg_new = {st_r.shreg[30:0], link.serial_in};
      end
      st_nxt.shreg = shreg_new; // unaffected by clear
      if (link.latch_clear) begin
         st_nxt.latch = sslc_pkg::SW_RESET;
      end else if (!link.latch_load_n) begin
         // transparent while low covers the falling edge
         st_nxt.latch = shreg_new;
      end // held while load high
      st_nxt.sout = shreg_new[sslc_pkg::NUM_SW-1];
      // one to one mapping, one means on
      st_nxt.sw = link.latch_clear ? sslc_pkg::SW_RESET : st_nxt.latch;
   end

   ////////////////////////////////////////////////////////////////////////
   // state register holds all stages and latches
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign switch_on       = st_r.sw;
   assign link.serial_out = st_r.sout;
endmodule

/* sslc_checker.sv */
/* link checker for the serial switch latch control.
 assumes one clock shared by both ends. */
`timescale 1ns/1ps
module sslc_checker (
   input wire logic clk,
   input wire logic resetn,
   input wire logic shift_clk,
   input wire logic serial_in,
   input wire logic serial_out,
   input wire logic latch_load_n,
   input wire logic latch_clear
);
   logic        prev_r;
   logic [31:0] mdl_r;
   logic [5:0]  cnt_r;
   wire         rise = shift_clk && !prev_r;
   ////////////////////////////////////////////////////////////////////////
   // shadow shift path, rebuilt from the wire only
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prev_r <= 1'h0;
         mdl_r  <= 32'h0;
         cnt_r  <= 6'h0;
      end else begin
         prev_r <= shift_clk;
         if (rise) mdl_r <= {mdl_r[30:0], serial_in};
         // count restarts at each strobe
         if (!latch_load_n) cnt_r <= 6'h0;
         else if (rise) cnt_r <= cnt_r + 6'h1;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence strobe_s;
      $fell(latch_load_n) ##1 latch_load_n;
   endsequence
   load_hold_a: assert property (rise |-> latch_load_n)
      else $error("shift during strobe");
   strobe_len_a: assert property ($fell(latch_load_n) |-> strobe_s)
      else $error("strobe not one cycle");
   full_load_a: assert property (
      $fell(latch_load_n) |-> cnt_r == 6'h20)
      else $error("strobe without 32 shifts");
   strobe_idle_a: assert property (
      $fell(latch_load_n) |-> !shift_clk)
      else $error("strobe with clock high");
   chain_out_a: assert property (serial_out == mdl_r[31])
      else $error("serial out not last stage");
   out_cause_a: assert property (
      $changed(serial_out) |-> $past(rise))
      else $error("serial out moved without shift");
   clear_keeps_a: assert property (
      latch_clear && !rise |=> $stable(serial_out))
      else $error("clear disturbed shift path");
   data_setup_a: assert property (rise |-> $stable(serial_in))
      else $error("data moved at shift");
endmodule

/* tb.sv */
/* testbench: host and device joined by the link.
 assumes the design files are compiled first. */
`timescale 1ns/1ps
module tb;
   logic        clk;
   logic        resetn;
   logic        start;
   logic [31:0] word;
   logic        clear;
   logic        busy;
   logic        chain_out;
   logic [31:0] switch_on;
   int          err_total;
   int          cmp_count;
   sslc_if bus ();
   sslc_host i_sslc_host (.clk(clk), .resetn(resetn), .link(bus.host),
      .start(start), .word(word), .clear(clear), .busy(busy),
      .chain_out(chain_out));
   sslc_device i_sslc_device (.clk(clk), .resetn(resetn),
      .link(bus.device), .switch_on(switch_on));
   sslc_checker i_sslc_checker (.clk(clk), .resetn(resetn),
      .shift_clk(bus.shift_clk), .serial_in(bus.serial_in),
      .serial_out(bus.serial_out), .latch_load_n(bus.latch_load_n),
      .latch_clear(bus.latch_clear));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   // one load; checked mid-shift since latches must not move then
   task automatic ld(input logic [31:0] w, input logic [31:0] old);
      @(posedge clk);
      start <= 1'h1;
      word  <= w;
      @(posedge clk);
      start <= 1'h0;
      repeat (10) @(negedge clk);
      chk(switch_on, old);
      for (int i = 0; i < 300 && busy !== 1'h0; i++) @(negedge clk);
      chk({31'h0, busy}, 32'h0);
      repeat (3) @(negedge clk);
   endtask
   task automatic give_verdict;
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      clk = 1'h0;
      forever #20 clk = ~clk;
   end
   // a hung handshake ends the run here
   initial begin
      #100us;
      err_total++;
      give_verdict();
   end
   initial begin
      resetn = 1'h0;
      start = 1'h0;
      word = 32'h0;
      clear = 1'h0;
      err_total = 0;
      cmp_count = 0;
      repeat (8) @(posedge clk);
      resetn <= 1'h1;
      ld(32'ha5c3_0f81, 32'h0);
      chk(switch_on, 32'ha5c3_0f81);
      chk({31'h0, chain_out}, 32'h1);
      ld(32'h5a3c_f07e, 32'ha5c3_0f81);
      chk(switch_on, 32'h5a3c_f07e);
      $display("test load done");
      @(posedge clk);
      clear <= 1'h1;
      repeat (3) @(negedge clk);
      chk(switch_on, 32'h0);
      ld(32'hffff_ffff, 32'h0);
      chk(switch_on, 32'h0);
      @(posedge clk);
      clear <= 1'h0;
      repeat (3) @(negedge clk);
      chk(switch_on, 32'h0);
      chk({31'h0, chain_out}, 32'h1);
      $display("test clear done");
      ld(32'h0000_0001, 32'h0);
      chk(switch_on, 32'h0000_0001);
      $display("test single done");
      give_verdict();
   end
endmodule
